// ### core/tcw_timer.v
// Top of the 16-bit waveform timer with an APB register slave
// Notes on behaviour
// - Clear mode zeroes counter at compare A/capture
// - Clear mode sets top register's flag at top
// - Clear mode top unbuffered; below count wraps past max
// - Clear mode output mode 1 toggles A
// - Pin shows wave only if direction, enable
// - Clear mode toggle rate: prescale and top
// - Clear mode overflow flag on max-to-zero
// - Modes 5,6,7,14,15 count up, restart bottom
// - Fast PWM tops; clear tick after top match
// - Mode 2 set on match, clear at top
// - Register tops from 0x0003 to full range
// - Fast PWM overflow and top flag at top
// - Fast PWM compare flag on each match
// - Fixed top masks written compare bits
// - Capture top unbuffered; miss wraps past max
// - Fast PWM compare writes buffered, loaded at top
// - Zero compare spikes; compare=top constant
// - Fast PWM mode 1 toggles A, 50%
// - PWM period is prescale times top plus one
// - Output mode 0 leaves output alone
// - Counter write blocks next tick's matches
`include "tcw_defines.vh"

module tcw_timer #(
  parameter ADDR_W = 8, // APB address width
  parameter CNT_W = 16 // Counter width
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Waveform pins
  output wire wave_a_pin_out,
  output wire wave_a_pin_oe,
  output wire wave_b_pin_out,
  output wire wave_b_pin_oe,
  // Internal wave states
  output wire wave_output_a,
  output wire wave_output_b
);

  // Software-visible state
  reg [`TCW_CTRL_W-1:0] ctrl_q; // Mode and prescaler
  reg [`TCW_OUT_W-1:0] outcfg_q; // Output modes, pin bits
  reg [CNT_W-1:0] counter_value_q; // Running count
  reg [CNT_W-1:0] cmp_buf_a_q; // Compare A buffer
  reg [CNT_W-1:0] cmp_buf_b_q; // Compare B buffer
  reg [CNT_W-1:0] compare_a_value_q; // Active compare A
  reg [CNT_W-1:0] compare_b_value_q; // Active compare B
  reg [CNT_W-1:0] capture_top_value_q; // Capture used as top
  reg [`TCW_FLG_W-1:0] flags_q; // Sticky event flags
  reg block_q; // Match blocking after count write

  // Next values
  reg [CNT_W-1:0] counter_value_d;
  reg [`TCW_FLG_W-1:0] flags_d;
  reg [`TCW_FLG_W-1:0] flag_set;

  // Decoded control
  wire [3:0] waveform_mode_select;
  wire [2:0] clk_select;
  wire tick;
  reg clear_on_compare_mode; // Clear-on-compare active
  reg fast_pwm; // Single-slope PWM active
  reg fixed_top; // 8, 9 or 10 bit top
  reg capture_is_top; // Capture register sets top
  reg [CNT_W-1:0] top_value; // Current top
  reg [CNT_W-1:0] cmp_mask; // Written compare mask

  // Events
  wire at_top;
  wire top_hit;
  wire wrap_max;
  wire match_a;
  wire match_b;

  // Bus decode
  wire acc;
  wire wr_en;
  wire rd_setup;
  wire addr_hit;
  wire [7:0] ofs;
  wire [CNT_W-1:0] wdata;
  reg [31:0] rd_mux;

  assign waveform_mode_select = ctrl_q[`TCW_CTRL_MODE];
  assign clk_select = ctrl_q[`TCW_CTRL_CLKSEL];

  // Timer tick from the prescaler
  tcw_prescaler u_pre (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .clk_select(clk_select),
    .tick(tick)
  );

  // Mode decode and top selection
  always @* begin
    clear_on_compare_mode = 1'b0;
    fast_pwm = 1'b0;
    fixed_top = 1'b0;
    capture_is_top = 1'b0;
    top_value = `TCW_MAX;
    case (waveform_mode_select)
      `TCW_MODE_CLR_A: begin
        clear_on_compare_mode = 1'b1;
        top_value = compare_a_value_q;
      end
      `TCW_MODE_CLR_CAP: begin
        clear_on_compare_mode = 1'b1;
        capture_is_top = 1'b1;
        top_value = capture_top_value_q;
      end
      `TCW_MODE_FP8: begin
        fast_pwm = 1'b1;
        fixed_top = 1'b1;
        top_value = `TCW_TOP8;
      end
      `TCW_MODE_FP9: begin
        fast_pwm = 1'b1;
        fixed_top = 1'b1;
        top_value = `TCW_TOP9;
      end
      `TCW_MODE_FP10: begin
        fast_pwm = 1'b1;
        fixed_top = 1'b1;
        top_value = `TCW_TOP10;
      end
      `TCW_MODE_FP_CAP: begin
        fast_pwm = 1'b1;
        capture_is_top = 1'b1;
        top_value = capture_top_value_q;
      end
      `TCW_MODE_FP_A: begin
        fast_pwm = 1'b1;
        top_value = compare_a_value_q;
      end
      default: begin
        // Other modes just run the full range
        top_value = `TCW_MAX;
      end
    endcase
    cmp_mask = fixed_top ? top_value : `TCW_MAX;
  end

  // Top and match detection; a count write blocks one tick
  assign at_top = (counter_value_q == top_value);
  assign top_hit = tick & at_top & ~block_q &
                   (clear_on_compare_mode | fast_pwm);
  assign wrap_max = tick & (counter_value_q == `TCW_MAX);
  assign match_a = tick & ~block_q &
                   (counter_value_q == compare_a_value_q);
  assign match_b = tick & ~block_q &
                   (counter_value_q == compare_b_value_q);

  // APB: zero-wait slave, error on unmapped offsets
  assign ofs = paddr[7:0];
  assign acc = psel & penable;
  assign wr_en = acc & pwrite & addr_hit;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign wdata = pwdata[CNT_W-1:0];
  assign addr_hit = (ofs == `TCW_OFS_CTRL) |
                    (ofs == `TCW_OFS_OUTCFG) |
                    (ofs == `TCW_OFS_COUNT) |
                    (ofs == `TCW_OFS_CMPA) |
                    (ofs == `TCW_OFS_CMPB) |
                    (ofs == `TCW_OFS_CAPT) |
                    (ofs == `TCW_OFS_FLAGS);
  assign pready = 1'b1;
  assign pslverr = acc & ~addr_hit;

  // Counter next value: write wins, then clear at top, else count
  always @* begin
    counter_value_d = counter_value_q;
    if (wr_en && ofs == `TCW_OFS_COUNT) begin
      counter_value_d = wdata;
    end else if (top_hit) begin
      counter_value_d = `TCW_BOTTOM;
    end else if (tick) begin
      // Missed top runs on through max and wraps
      counter_value_d = counter_value_q +
                        {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // Flag events
  always @* begin
    flag_set = {`TCW_FLG_W{1'b0}};
    if (fast_pwm) begin
      flag_set[`TCW_FLG_OVF] = top_hit;
    end else begin
      flag_set[`TCW_FLG_OVF] = wrap_max;
    end
    // Compare A flag also marks top in modes 4 and 15
    flag_set[`TCW_FLG_CMPA] = match_a;
    flag_set[`TCW_FLG_CMPB] = match_b;
    flag_set[`TCW_FLG_CAPT] = top_hit & capture_is_top;
  end

  // Write one to clear; a new event beats the clear
  always @* begin
    flags_d = flags_q;
    if (wr_en && ofs == `TCW_OFS_FLAGS) begin
      flags_d = flags_q & ~pwdata[`TCW_FLG_W-1:0];
    end
    flags_d = flags_d | flag_set;
  end

  // Control and configuration registers
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= `TCW_CTRL_RST;
      outcfg_q <= `TCW_OUT_RST;
    end else begin
      if (wr_en && ofs == `TCW_OFS_CTRL) begin
        ctrl_q <= pwdata[`TCW_CTRL_W-1:0];
      end
      // Output mode changes gate the pin at once, the wave at next match or top
      if (wr_en && ofs == `TCW_OFS_OUTCFG) begin
        outcfg_q <= pwdata[`TCW_OUT_W-1:0];
      end
    end
  end

  // Counter, flags and blocking
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      counter_value_q <= {CNT_W{1'b0}};
      flags_q <= {`TCW_FLG_W{1'b0}};
      block_q <= 1'b0;
    end else begin
      counter_value_q <= counter_value_d;
      flags_q <= flags_d;
      // Held even while stopped, until a tick consumes it
      if (wr_en && ofs == `TCW_OFS_COUNT) begin
        block_q <= 1'b1;
      end else if (tick) begin
        block_q <= 1'b0;
      end
    end
  end

  // Capture register as top: no buffer, takes effect at once
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      capture_top_value_q <= {CNT_W{1'b0}};
    end else if (wr_en && ofs == `TCW_OFS_CAPT) begin
      capture_top_value_q <= wdata;
    end
  end

  // Compare buffers and active compare values
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cmp_buf_a_q <= {CNT_W{1'b0}};
      cmp_buf_b_q <= {CNT_W{1'b0}};
      compare_a_value_q <= {CNT_W{1'b0}};
      compare_b_value_q <= {CNT_W{1'b0}};
    end else begin
      if (wr_en && ofs == `TCW_OFS_CMPA) begin
        cmp_buf_a_q <= wdata & cmp_mask;
      end
      if (wr_en && ofs == `TCW_OFS_CMPB) begin
        cmp_buf_b_q <= wdata & cmp_mask;
      end
      if (fast_pwm) begin
        // Glitch-free period change: load only at top
        if (top_hit) begin
          compare_a_value_q <= cmp_buf_a_q;
          compare_b_value_q <= cmp_buf_b_q;
        end
      end else begin
        // Without buffering, writes hit the comparator now
        if (wr_en && ofs == `TCW_OFS_CMPA) begin
          compare_a_value_q <= wdata & cmp_mask;
        end
        if (wr_en && ofs == `TCW_OFS_CMPB) begin
          compare_b_value_q <= wdata & cmp_mask;
        end
      end
    end
  end

  // Read mux; buffered compare shows what software wrote
  always @* begin
    rd_mux = 32'h0000_0000;
    case (ofs)
      `TCW_OFS_CTRL: rd_mux[`TCW_CTRL_W-1:0] = ctrl_q;
      `TCW_OFS_OUTCFG: rd_mux[`TCW_OUT_W-1:0] = outcfg_q;
      `TCW_OFS_COUNT: rd_mux[CNT_W-1:0] = counter_value_q;
      `TCW_OFS_CMPA: rd_mux[CNT_W-1:0] = fast_pwm ?
        cmp_buf_a_q : compare_a_value_q;
      `TCW_OFS_CMPB: rd_mux[CNT_W-1:0] = fast_pwm ?
        cmp_buf_b_q : compare_b_value_q;
      `TCW_OFS_CAPT: rd_mux[CNT_W-1:0] = capture_top_value_q;
      `TCW_OFS_FLAGS: rd_mux[`TCW_FLG_W-1:0] = flags_q;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data captured in the setup cycle, held through access
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= rd_mux;
    end
  end

  // Per-channel compare output units
  wire [1:0] ch_match;
  wire [1:0] ch_wave;
  wire [1:0] ch_pin_out;
  wire [1:0] ch_pin_oe;
  wire [3:0] ch_mode;
  wire [1:0] ch_pen;
  wire [1:0] ch_dir;

  assign ch_match = {match_b, match_a};
  assign ch_mode = {outcfg_q[`TCW_OUT_COM_B],
                    outcfg_q[`TCW_OUT_COM_A]};
  assign ch_pen = {outcfg_q[`TCW_OUT_PEN_B],
                   outcfg_q[`TCW_OUT_PEN_A]};
  assign ch_dir = {outcfg_q[`TCW_OUT_DIR_B],
                   outcfg_q[`TCW_OUT_DIR_A]};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_ch
      // Only channel A may toggle in fast PWM
      tcw_channel #(
        .TOGGLE_IN_PWM(gi == 0)
      ) u_ch (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .match(ch_match[gi]),
        .wrap(top_hit),
        .fast_pwm(fast_pwm),
        .out_mode(ch_mode[2*gi+1:2*gi]),
        .pin_enable(ch_pen[gi]),
        .pin_direction(ch_dir[gi]),
        .wave_q(ch_wave[gi]),
        .pin_out(ch_pin_out[gi]),
        .pin_oe(ch_pin_oe[gi])
      );
    end
  endgenerate

  // Pin and wave outputs
  assign wave_a_pin_out = ch_pin_out[0];
  assign wave_a_pin_oe = ch_pin_oe[0];
  assign wave_b_pin_out = ch_pin_out[1];
  assign wave_b_pin_oe = ch_pin_oe[1];
  assign wave_output_a = ch_wave[0];
  assign wave_output_b = ch_wave[1];

endmodule

// ### core/tcw_defines.vh
// Shared constants of the waveform timer: map, fields, modes, tops
`ifndef TCW_DEFINES_VH
`define TCW_DEFINES_VH

// Register byte offsets
`define TCW_OFS_CTRL 8'h00
`define TCW_OFS_OUTCFG 8'h04
`define TCW_OFS_COUNT 8'h08
`define TCW_OFS_CMPA 8'h0c
`define TCW_OFS_CMPB 8'h10
`define TCW_OFS_CAPT 8'h14
`define TCW_OFS_FLAGS 8'h18

// Control register fields
`define TCW_CTRL_MODE 3:0
`define TCW_CTRL_CLKSEL 6:4
`define TCW_CTRL_W 7
`define TCW_CTRL_RST 7'h00

// Output configuration fields
`define TCW_OUT_COM_A 1:0
`define TCW_OUT_COM_B 3:2
`define TCW_OUT_PEN_A 4
`define TCW_OUT_PEN_B 5
`define TCW_OUT_DIR_A 6
`define TCW_OUT_DIR_B 7
`define TCW_OUT_W 8
`define TCW_OUT_RST 8'h00

// Flag bits
`define TCW_FLG_OVF 0
`define TCW_FLG_CMPA 1
`define TCW_FLG_CMPB 2
`define TCW_FLG_CAPT 3
`define TCW_FLG_W 4

// Waveform mode codes
`define TCW_MODE_CLR_A 4'h4
`define TCW_MODE_FP8 4'h5
`define TCW_MODE_FP9 4'h6
`define TCW_MODE_FP10 4'h7
`define TCW_MODE_CLR_CAP 4'hc
`define TCW_MODE_FP_CAP 4'he
`define TCW_MODE_FP_A 4'hf

// Fixed top values and limits
`define TCW_TOP8 16'h00ff
`define TCW_TOP9 16'h01ff
`define TCW_TOP10 16'h03ff
`define TCW_MAX 16'hffff
`define TCW_BOTTOM 16'h0000

// Output mode codes
`define TCW_COM_NONE 2'h0
`define TCW_COM_TOGGLE 2'h1
`define TCW_COM_CLEAR 2'h2
`define TCW_COM_SET 2'h3

// Prescaler selections and tap masks (1, 8, 64, 256, 1024)
`define TCW_CS_STOP 3'h0
`define TCW_CS_DIV1 3'h1
`define TCW_CS_DIV8 3'h2
`define TCW_CS_DIV64 3'h3
`define TCW_CS_DIV256 3'h4
`define TCW_CS_DIV1024 3'h5
`define TCW_PRE_M8 10'h007
`define TCW_PRE_M64 10'h03f
`define TCW_PRE_M256 10'h0ff
`define TCW_PRE_M1024 10'h3ff

`endif

// ### core/tcw_prescaler.v
// Prescaler making the timer tick from the I/O clock
`include "tcw_defines.vh"

module tcw_prescaler (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Divider selection
  input wire [2:0] clk_select,
  // One-cycle timer tick
  output reg tick
);

  reg [9:0] div_q; // Free-running divider
  reg [9:0] mask; // Tap mask for the selection

  // Divider runs always, so a ratio change never stalls
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 10'h000;
    end else begin
      div_q <= div_q + 10'h001;
    end
  end

  // Tick when the selected low bits are all ones
  always @* begin
    tick = 1'b0;
    mask = 10'h000;
    case (clk_select)
      `TCW_CS_DIV1: tick = 1'b1;
      `TCW_CS_DIV8: mask = `TCW_PRE_M8;
      `TCW_CS_DIV64: mask = `TCW_PRE_M64;
      `TCW_CS_DIV256: mask = `TCW_PRE_M256;
      `TCW_CS_DIV1024: mask = `TCW_PRE_M1024;
      default: mask = 10'h000; // Stopped
    endcase
    if (mask != 10'h000) begin
      tick = ((div_q & mask) == mask);
    end
  end

endmodule

// ### core/tcw_channel.v
// Compare output unit: wave state and pin override of one channel
`include "tcw_defines.vh"

module tcw_channel #(
  parameter TOGGLE_IN_PWM = 1 // Channel may toggle in fast PWM
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Events from the counter
  input wire match,
  input wire wrap,
  input wire fast_pwm,
  // Configuration
  input wire [1:0] out_mode,
  input wire pin_enable,
  input wire pin_direction,
  // Results
  output reg wave_q,
  output wire pin_out,
  output wire pin_oe
);

  reg wave_d; // Next wave state

  // Set, clear or toggle; a match beats the top action
  always @* begin
    wave_d = wave_q;
    if (fast_pwm) begin
      if (wrap && out_mode == `TCW_COM_CLEAR) begin
        wave_d = 1'b0;
      end else if (wrap && out_mode == `TCW_COM_SET) begin
        wave_d = 1'b1;
      end
      if (match) begin
        case (out_mode)
          `TCW_COM_TOGGLE: wave_d = (TOGGLE_IN_PWM != 0) ?
            ~wave_q : wave_q;
          `TCW_COM_CLEAR: wave_d = 1'b1;
          `TCW_COM_SET: wave_d = 1'b0;
          default: wave_d = wave_q;
        endcase
      end
    end else if (match) begin
      case (out_mode)
        `TCW_COM_TOGGLE: wave_d = ~wave_q;
        `TCW_COM_CLEAR: wave_d = 1'b0;
        `TCW_COM_SET: wave_d = 1'b1;
        default: wave_d = wave_q;
      endcase
    end
  end

  // Wave state register, zero after reset
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wave_q <= 1'b0;
    end else begin
      wave_q <= wave_d;
    end
  end

  // Pin shows the wave only with direction and enable both set
  assign pin_oe = pin_direction;
  assign pin_out = pin_direction & pin_enable &
                   (out_mode != `TCW_COM_NONE) & wave_q;

endmodule

// ### sim/tcw_timer_properties.sv
// Port checks of the waveform timer, bound to its top
`include "tcw_defines.vh"
module tcw_timer_checker #(
  parameter ADDR_W = 8,
  parameter CNT_W = 16
) (
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Pins and wave states
  input wire wave_a_pin_out,
  input wire wave_a_pin_oe,
  input wire wave_b_pin_out,
  input wire wave_b_pin_oe,
  input wire wave_output_a,
  input wire wave_output_b
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // Access phase of a write to the output configuration
  wire cfg_acc = psel && penable && pwrite && paddr == `TCW_OFS_OUTCFG;
  // Shadow of the output configuration
  logic [7:0] cfg_q;
  // Updated on the access edge, as the slave does
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg_q <= 8'h00;
    end else if (cfg_acc) begin
      cfg_q <= pwdata[7:0];
    end
  end
  // Setup then access of a configuration write
  sequence s_cfg_wr;
    psel && !penable && pwrite && paddr == `TCW_OFS_OUTCFG ##1 cfg_acc;
  endsequence
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_err_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  a_err_unmapped: assert property (
    psel && penable && paddr > `TCW_OFS_FLAGS |-> pslverr)
    else $error("unmapped access not refused");
  a_ok_mapped: assert property (psel && penable && paddr[1:0] == 2'h0
    && paddr <= `TCW_OFS_FLAGS |-> !pslverr)
    else $error("mapped access refused");
  a_prdata_hold: assert property (
    !(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("prdata moved without read setup");
  a_oe_dir: assert property (s_cfg_wr |=>
    wave_a_pin_oe == $past(pwdata[6]) && wave_b_pin_oe == $past(pwdata[7]))
    else $error("pin enable not from direction bit");
  a_pin_a_gate: assert property (wave_a_pin_out == (cfg_q[6] &&
    cfg_q[4] && cfg_q[1:0] != 2'h0 && wave_output_a))
    else $error("pin A gating wrong");
  a_pin_b_gate: assert property (wave_b_pin_out == (cfg_q[7] &&
    cfg_q[5] && cfg_q[3:2] != 2'h0 && wave_output_b))
    else $error("pin B gating wrong");
  a_idle_a_holds: assert property (
    cfg_q[1:0] == 2'h0 |=> $stable(wave_output_a))
    else $error("wave A moved with output mode 0");
  a_idle_b_holds: assert property (
    cfg_q[3:2] == 2'h0 |=> $stable(wave_output_b))
    else $error("wave B moved with output mode 0");
endmodule
bind tcw_timer tcw_timer_checker #(.ADDR_W(ADDR_W), .CNT_W(CNT_W))
  tcw_timer_checker_inst (.clk_sys(clk_sys), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .wave_a_pin_out(wave_a_pin_out), .wave_a_pin_oe(wave_a_pin_oe),
  .wave_b_pin_out(wave_b_pin_out), .wave_b_pin_oe(wave_b_pin_oe),
  .wave_output_a(wave_output_a), .wave_output_b(wave_output_b));

// ### sim/tcw_pin_load.sv
// Loads on the two waveform pins, each pad with a weak pull-up
module tcw_pin_load (
  // Pin A
  input wire wave_a_pin_out,
  input wire wave_a_pin_oe,
  // Pin B
  input wire wave_b_pin_out,
  input wire wave_b_pin_oe,
  // Pad levels
  output wire pad_a,
  output wire pad_b
);
  timeunit 1ns;
  timeprecision 1ns;
  // A released pad is pulled high, never left at the last value
  assign pad_a = wave_a_pin_oe ? wave_a_pin_out : 1'b1;
  assign pad_b = wave_b_pin_oe ? wave_b_pin_out : 1'b1;
endmodule

// ### sim/tb_tcw_timer.sv
// Self-checking bench of the waveform timer
`include "tcw_defines.vh"
module tb_tcw_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire [31:0] prdata;
  wire pready, pslverr, pa_out, pa_oe, pb_out, pb_oe, wave_a, wave_b;
  wire pad_a, pad_b;
  int err_total = 0;
  int total_checks = 0;
  // Expected read data and masks, oldest first
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int hi_n;
  int lo_n;
  // 25 MHz clock
  always #20 clk_sys = ~clk_sys;
  tcw_timer tcw_timer_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wave_a_pin_out(pa_out), .wave_a_pin_oe(pa_oe),
    .wave_b_pin_out(pb_out), .wave_b_pin_oe(pb_oe),
    .wave_output_a(wave_a), .wave_output_b(wave_b));
  tcw_pin_load tcw_pin_load_inst (.wave_a_pin_out(pa_out),
    .wave_a_pin_oe(pa_oe), .wave_b_pin_out(pb_out), .wave_b_pin_oe(pb_oe),
    .pad_a(pad_a), .pad_b(pad_b));
  // Verdict and end of run
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Word compare
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Single bit compare
  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({31'h0, got}, {31'h0, exp});
  endtask
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      err_total++;
      final_report();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  // Read with its expectation noted for the monitor
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
      input logic [31:0] m);
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask
  // Monitor: each completed read takes the oldest note
  always @(posedge clk_sys) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      cmp_word(prdata & msk_q.pop_front(), exp_q.pop_front());
    end
  end
  // Cycles until pad A reaches a level, bounded
  task automatic wait_pad(input logic lvl, output int cyc);
    cyc = 0;
    while (pad_a !== lvl && cyc < 40000) begin
      @(posedge clk_sys);
      cyc++;
    end
    if (cyc >= 40000) begin
      err_total++;
      final_report();
    end
  endtask
  // Stopped setup, then start with the given divider
  task automatic setw(input logic [3:0] m, input logic [2:0] cs,
      input logic [15:0] c, input logic [15:0] t, input logic [1:0] com);
    wr(`TCW_OFS_CTRL, {28'h0, m});
    wr(`TCW_OFS_COUNT, 32'h0);
    wr(`TCW_OFS_CAPT, {16'h0, t});
    wr(`TCW_OFS_CMPA, {16'h0, c});
    wr(`TCW_OFS_OUTCFG, {24'h0, 6'h3c, com});
    wr(`TCW_OFS_CTRL, {25'h0, cs, m});
  endtask
  // Skip the settling period, then time one high and one low phase
  task automatic wave(input logic [3:0] m, input logic [2:0] cs,
      input logic [15:0] c, input logic [15:0] t, input logic [1:0] com,
      input int ehi, input int elo);
    int x;
    setw(m, cs, c, t, com);
    wait_pad(1'b1, x);
    wait_pad(1'b0, x);
    wait_pad(1'b1, x);
    wait_pad(1'b0, hi_n);
    wait_pad(1'b1, lo_n);
    cmp_word(32'(hi_n), 32'(ehi));
    cmp_word(32'(lo_n), 32'(elo));
  endtask
  initial begin
    int p;
    int nn;
    int c;
    void'($urandom(52));
    repeat (10) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    // Reset values and the unmapped hole
    rd(`TCW_OFS_CTRL, 32'h0, 32'hffffffff);
    rd(`TCW_OFS_OUTCFG, 32'h0, 32'hffffffff);
    rd(`TCW_OFS_COUNT, 32'h0, 32'hffffffff);
    rd(`TCW_OFS_FLAGS, 32'h0, 32'hffffffff);
    rd(8'h1c, 32'h0, 32'hffffffff);
    // Fixed tops mask written compare bits
    for (int m = 5; m <= 7; m++) begin
      wr(`TCW_OFS_CTRL, 32'(m));
      wr(`TCW_OFS_CMPB, 32'hffff);
      rd(`TCW_OFS_CMPB, (32'h100 << (m - 5)) - 1, 32'hffff);
    end
    // Toggle in clear-on-compare at every divider
    p = 1;
    for (int k = 1; k <= 5; k++) begin
      nn = 1 + $urandom % 3;
      wave(4'h4, 3'(k), 16'(nn), 16'h0, 2'h1, (nn + 1) * p, (nn + 1) * p);
      p = (k < 3) ? p * 8 : p * 4;
    end
    nn = 3 + $urandom % 5;
    wave(4'hc, 3'h1, 16'(nn), 16'(nn), 2'h1, nn + 1, nn + 1);
    // Fast PWM tops, polarities and extremes; compares kept within top
    c = 16 + $urandom % 200;
    wave(4'h5, 3'h1, 16'(c), 16'h0, 2'h2, 255 - c, c + 1);
    wave(4'h6, 3'h1, 16'h100, 16'h0, 2'h3, 257, 255);
    wave(4'h7, 3'h1, 16'h0, 16'h0, 2'h2, 1023, 1);
    wave(4'he, 3'h1, 16'h1, 16'h3, 2'h2, 2, 2);
    wave(4'hf, 3'h1, 16'h5, 16'h0, 2'h1, 6, 6);
    // Compare equal to top holds the pad high
    setw(4'h5, 3'h1, 16'hff, 16'h0, 2'h2);
    repeat (600) @(posedge clk_sys);
    nn = 0;
    repeat (300) begin
      @(posedge clk_sys);
      nn += (pad_a !== 1'b1);
    end
    cmp_word(32'(nn), 32'h0);
    // Pin gating by enable, then by direction
    wr(`TCW_OFS_OUTCFG, 32'h42);
    @(negedge clk_sys);
    cmp_bit(pad_a, 1'b0);
    @(posedge clk_sys);
    wr(`TCW_OFS_OUTCFG, 32'h12);
    @(negedge clk_sys);
    cmp_bit(pa_oe, 1'b0);
    cmp_bit(pad_a, 1'b1);
    @(posedge clk_sys);
    // Counter write blocks the next match; flags at match and top
    wr(`TCW_OFS_CTRL, 32'h4);
    wr(`TCW_OFS_CMPB, 32'h10);
    wr(`TCW_OFS_CTRL, 32'h5);
    wr(`TCW_OFS_CMPB, 32'h10);
    wr(`TCW_OFS_COUNT, 32'h10);
    wr(`TCW_OFS_FLAGS, 32'hf);
    // Channel B inverting on its pin: direction, enable, mode 2
    wr(`TCW_OFS_OUTCFG, 32'ha8);
    wr(`TCW_OFS_CTRL, 32'h15);
    rd(`TCW_OFS_FLAGS, 32'h0, 32'h4);
    repeat (300) @(posedge clk_sys);
    rd(`TCW_OFS_FLAGS, 32'h5, 32'h5);
    // Past the B match and well before the next top: pad B is high
    cmp_bit(pad_b, 1'b1);
    // Top below count: run to max, wrap, then match
    wr(`TCW_OFS_CTRL, 32'h4);
    wr(`TCW_OFS_CMPA, 32'h40);
    wr(`TCW_OFS_COUNT, 32'hfff0);
    wr(`TCW_OFS_FLAGS, 32'hf);
    wr(`TCW_OFS_CTRL, 32'h14);
    rd(`TCW_OFS_FLAGS, 32'h0, 32'h3);
    repeat (40) @(posedge clk_sys);
    rd(`TCW_OFS_FLAGS, 32'h1, 32'h3);
    repeat (60) @(posedge clk_sys);
    rd(`TCW_OFS_FLAGS, 32'h3, 32'h3);
    final_report();
  end
endmodule
